/* File: src/fsg_consts.svh */
/*
 * Timing and reset constants for the frame-sync output generator.
 * Assumes a single system clock; included by bare name.
 */
`ifndef FSG_CONSTS_SVH
`define FSG_CONSTS_SVH

// system clock period, ns
`define FSG_CLK_PERIOD_NS     100
// frame period (8 kHz), ns
`define FSG_FRAME_PERIOD_NS   125000
// multiframe period (2 kHz), ns
`define FSG_MFRAME_PERIOD_NS  500000
// frames in one multiframe
`define FSG_FRAMES_PER_MFRAME 4
// output pin level during reset and while disabled
`define FSG_PIN_RST           1'b0
// longest wait, in system cycles, for an output clock three edge
`define FSG_CLK3_WAIT_MAX     16

`endif

/* File: src/fsg_pkg.sv */
/*
 * Types shared by the frame-sync output generator files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fsg_pkg;

    // per-output configuration
    typedef struct packed {
        logic out_enable;
        logic pulse_mode;
        logic invert;
    } fsg_cfg_s;

    // pulse sequencer states
    typedef enum logic [1:0] {
        FSG_IDLE = 2'b00,
        FSG_ARM  = 2'b01,
        FSG_LOW  = 2'b10
    } fsg_state_e;

endpackage : fsg_pkg

/* File: src/fsg_chan.sv */
/*
 * One frame-sync output channel: square clock or one-period low pulse,
 * optional inversion, enable gating to a low pin.
 * Assumes tick, square and clock three rise come from logic on clk_sys_i.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fsg_consts.svh"

module fsg_chan (
    // clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             arst_n_i,
    input  wire logic             ce_i,
    // timing from the alignment generator and the clock three edge detect
    input  wire logic             tick_i,
    input  wire logic             square_i,
    input  wire logic             clk3_rise_i,
    // configuration
    input  wire fsg_pkg::fsg_cfg_s cfg_i,
    // pin
    output logic                  pin_o
);
    import fsg_pkg::*;

    localparam int CLK3_WAIT_MAX = `FSG_CLK3_WAIT_MAX;

    fsg_state_e state_reg;
    fsg_state_e state_next;
    logic       pin_reg;
    logic       pin_next;
    logic       raw;

    // ==========================================================
    // pulse sequencer and pin
    always_comb begin
        state_next = state_reg;
        pin_next   = pin_reg;
        raw        = 1'b0;
        if (ce_i) begin
            case (state_reg)
                FSG_IDLE: begin
                    if (tick_i && cfg_i.pulse_mode) begin
                        state_next = FSG_ARM;
                    end
                end
                FSG_ARM: begin
                    if (clk3_rise_i) begin
                        state_next = FSG_LOW;
                    end
                end
                FSG_LOW: begin
                    if (clk3_rise_i) begin
                        state_next = FSG_IDLE;
                    end
                end
                default: begin
                    state_next = FSG_IDLE;
                end
            endcase
            if (!cfg_i.pulse_mode) begin
                state_next = FSG_IDLE;
            end
            raw = cfg_i.pulse_mode ? (state_next != FSG_LOW) : square_i;
            if (cfg_i.out_enable) begin
                pin_next = raw ^ cfg_i.invert;
            end else begin
                pin_next = `FSG_PIN_RST;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= FSG_IDLE;
            pin_reg   <= `FSG_PIN_RST;
        end else begin
            state_reg <= state_next;
            pin_reg   <= pin_next;
        end
    end

    assign pin_o = pin_reg;

    // ==========================================================
    // checks
    sequence s_armed;
        tick_i && cfg_i.pulse_mode && cfg_i.out_enable && state_reg == FSG_IDLE;
    endsequence

    property p_pulse_start;
        @(posedge clk_sys_i) disable iff (!arst_n_i || !ce_i)
        state_reg == FSG_ARM && clk3_rise_i && cfg_i.pulse_mode && cfg_i.out_enable
            |=> pin_reg == cfg_i.invert;
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("pulse did not start on clock three edge");

    property p_pulse_end;
        @(posedge clk_sys_i) disable iff (!arst_n_i || !ce_i)
        state_reg == FSG_LOW && clk3_rise_i && cfg_i.pulse_mode && cfg_i.out_enable
            |=> pin_reg == !cfg_i.invert && state_reg == FSG_IDLE;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("pulse not one clock three period long");

    property p_arm_bound;
        @(posedge clk_sys_i) disable iff (!arst_n_i || !ce_i)
        s_armed |=> ##[0:CLK3_WAIT_MAX] state_reg == FSG_LOW;
    endproperty
    a_arm_bound: assert property (p_arm_bound) else $error("pulse not issued after boundary");

endmodule : fsg_chan

`default_nettype wire

/* File: src/fsg_top.sv */
/*
 * Frame-sync output generator: 8 kHz frame and 2 kHz multiframe pins
 * driven from one shared 2 kHz alignment generator.
 * Assumes config bits are static logic on clk_sys_i and that output
 * clock three arrives asynchronously, well below half of clk_sys_i.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fsg_consts.svh"

module fsg_top #(
    parameter int PERIOD_2K_CYC = `FSG_MFRAME_PERIOD_NS / `FSG_CLK_PERIOD_NS
) (
    // clock, reset, enable
    input  wire logic clk_sys_i,
    input  wire logic arst_n_i,
    input  wire logic ce_i,
    // frame output configuration
    input  wire logic frame_out_enable_i,
    input  wire logic pulse_mode_8k_i,
    input  wire logic invert_8k_i,
    // multiframe output configuration
    input  wire logic multiframe_out_enable_i,
    input  wire logic pulse_mode_2k_i,
    input  wire logic invert_2k_i,
    // pulse-width clock from the main timing path
    input  wire logic output_clock_three_i,
    // output pins
    output logic      frame_sync_8k_out_o,
    output logic      multiframe_sync_2k_out_o
);
    import fsg_pkg::*;

    localparam int P8_CYC = PERIOD_2K_CYC / `FSG_FRAMES_PER_MFRAME;
    localparam int CNT_W  = $clog2(PERIOD_2K_CYC);
    localparam logic [CNT_W-1:0] P2_LAST = CNT_W'(PERIOD_2K_CYC - 1);
    localparam logic [CNT_W-1:0] P2_HALF = CNT_W'(PERIOD_2K_CYC / 2);
    localparam logic [CNT_W-1:0] P8_LAST = CNT_W'(P8_CYC - 1);
    localparam logic [CNT_W-1:0] P8_HALF = CNT_W'(P8_CYC / 2);

    // ==========================================================
    // output clock three synchroniser and edge detect
    logic [2:0] clk3_sync_reg;
    logic [2:0] clk3_sync_next;
    logic       clk3_lvl_reg;
    logic       clk3_lvl_next;
    logic       clk3_rise_reg;
    logic       clk3_rise_next;

    always_comb begin
        clk3_sync_next = clk3_sync_reg;
        clk3_lvl_next  = clk3_lvl_reg;
        clk3_rise_next = 1'b0;
        if (ce_i) begin
            clk3_sync_next = {clk3_sync_reg[1:0], output_clock_three_i};
            if (clk3_sync_reg[1] == clk3_sync_reg[2]) begin
                clk3_lvl_next  = clk3_sync_reg[1];
                clk3_rise_next = clk3_sync_reg[1] && !clk3_lvl_reg;
            end
        end else begin
            clk3_rise_next = clk3_rise_reg;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            clk3_sync_reg <= 3'h0;
            clk3_lvl_reg  <= 1'b0;
            clk3_rise_reg <= 1'b0;
        end else begin
            clk3_sync_reg <= clk3_sync_next;
            clk3_lvl_reg  <= clk3_lvl_next;
            clk3_rise_reg <= clk3_rise_next;
        end
    end

    // ==========================================================
    // shared 2 kHz alignment generator
    logic [CNT_W-1:0] cnt2_reg;
    logic [CNT_W-1:0] cnt2_next;
    logic [CNT_W-1:0] cnt8_reg;
    logic [CNT_W-1:0] cnt8_next;
    logic             tick_2k;
    logic             tick_8k;
    logic             square_2k;
    logic             square_8k;

    assign tick_2k   = (cnt2_reg == P2_LAST);
    assign tick_8k   = (cnt8_reg == P8_LAST);
    // low half first, so the falling edge lands on the boundary
    assign square_2k = (cnt2_reg >= P2_HALF);
    assign square_8k = (cnt8_reg >= P8_HALF);

    always_comb begin
        cnt2_next = cnt2_reg;
        cnt8_next = cnt8_reg;
        if (ce_i) begin
            cnt2_next = tick_2k ? '0 : cnt2_reg + 1'b1;
            // frame counter restarts with the multiframe boundary
            cnt8_next = (tick_2k || tick_8k) ? '0 : cnt8_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt2_reg <= '0;
            cnt8_reg <= '0;
        end else begin
            cnt2_reg <= cnt2_next;
            cnt8_reg <= cnt8_next;
        end
    end

    // ==========================================================
    // output channels
    fsg_cfg_s cfg_8k;
    fsg_cfg_s cfg_2k;

    assign cfg_8k = '{out_enable: frame_out_enable_i, pulse_mode: pulse_mode_8k_i, invert: invert_8k_i};
    assign cfg_2k = '{out_enable: multiframe_out_enable_i, pulse_mode: pulse_mode_2k_i, invert: invert_2k_i};

    fsg_chan u_chan_8k (
        .clk_sys_i  (clk_sys_i),
        .arst_n_i   (arst_n_i),
        .ce_i       (ce_i),
        .tick_i     (tick_8k),
        .square_i    (square_8k),
        .clk3_rise_i (clk3_rise_reg),
        .cfg_i      (cfg_8k),
        .pin_o      (frame_sync_8k_out_o)
    );

    fsg_chan u_chan_2k (
        .clk_sys_i  (clk_sys_i),
        .arst_n_i   (arst_n_i),
        .ce_i       (ce_i),
        .tick_i     (tick_2k),
        .square_i    (square_2k),
        .clk3_rise_i (clk3_rise_reg),
        .cfg_i      (cfg_2k),
        .pin_o      (multiframe_sync_2k_out_o)
    );

    // ==========================================================
    // checks
    sequence s_fall_8k;
        frame_sync_8k_out_o ##1 !frame_sync_8k_out_o;
    endsequence

    sequence s_rise_8k;
        !frame_sync_8k_out_o ##1 frame_sync_8k_out_o;
    endsequence

    sequence s_fall_2k;
        multiframe_sync_2k_out_o ##1 !multiframe_sync_2k_out_o;
    endsequence

    sequence s_rise_2k;
        !multiframe_sync_2k_out_o ##1 multiframe_sync_2k_out_o;
    endsequence

    property p_gen_align;
        @(posedge clk_sys_i) disable iff (!arst_n_i || !ce_i)
        tick_2k |-> tick_8k;
    endproperty
    a_gen_align: assert property (p_gen_align) else $error("frame and multiframe boundaries apart");

    property p_8k_fall;
        @(posedge clk_sys_i) disable iff (!arst_n_i || !ce_i)
        frame_out_enable_i && !pulse_mode_8k_i && !invert_8k_i && tick_8k |=> s_fall_8k;
    endproperty
    a_8k_fall: assert property (p_8k_fall) else $error("frame clock not falling at boundary");

    property p_8k_rise;
        @(posedge clk_sys_i) disable iff (!arst_n_i || !ce_i)
        frame_out_enable_i && !pulse_mode_8k_i && !invert_8k_i && cnt8_reg == P8_HALF - 1'b1 |=> s_rise_8k;
    endproperty
    a_8k_rise: assert property (p_8k_rise) else $error("frame clock not rising at half period");

    property p_8k_inv;
        @(posedge clk_sys_i) disable iff (!arst_n_i || !ce_i)
        frame_out_enable_i && !pulse_mode_8k_i && invert_8k_i && tick_8k |=> s_rise_8k;
    endproperty
    a_8k_inv: assert property (p_8k_inv) else $error("frame clock not inverted");

    property p_2k_fall;
        @(posedge clk_sys_i) disable iff (!arst_n_i || !ce_i)
        multiframe_out_enable_i && !pulse_mode_2k_i && !invert_2k_i && tick_2k |=> s_fall_2k;
    endproperty
    a_2k_fall: assert property (p_2k_fall) else $error("multiframe clock not falling at boundary");

    property p_2k_rise;
        @(posedge clk_sys_i) disable iff (!arst_n_i || !ce_i)
        multiframe_out_enable_i && !pulse_mode_2k_i && !invert_2k_i && cnt2_reg == P2_HALF - 1'b1
            |=> s_rise_2k;
    endproperty
    a_2k_rise: assert property (p_2k_rise) else $error("multiframe clock not rising at half period");

    property p_2k_inv;
        @(posedge clk_sys_i) disable iff (!arst_n_i || !ce_i)
        multiframe_out_enable_i && !pulse_mode_2k_i && invert_2k_i && tick_2k |=> s_rise_2k;
    endproperty
    a_2k_inv: assert property (p_2k_inv) else $error("multiframe clock not inverted");

    property p_8k_off;
        @(posedge clk_sys_i) disable iff (!arst_n_i || !ce_i)
        !frame_out_enable_i |=> !frame_sync_8k_out_o;
    endproperty
    a_8k_off: assert property (p_8k_off) else $error("disabled frame pin not low");

    property p_2k_off;
        @(posedge clk_sys_i) disable iff (!arst_n_i || !ce_i)
        !multiframe_out_enable_i |=> !multiframe_sync_2k_out_o;
    endproperty
    a_2k_off: assert property (p_2k_off) else $error("disabled multiframe pin not low");

endmodule : fsg_top

`default_nettype wire

/* File: bench/fsg_oc3_src.sv */
/*
 * Model of the main timing path feeding output clock three.
 * Assumes the block samples it on its own 10 MHz system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module fsg_clk3_src (
    // rate select: 0 gives 2 MHz, 1 gives 1.667 MHz
    input  wire logic slow_i,
    // clock to the block
    output logic      clk3_o
);

    // ==========================================
    // free-running clock, offset from clk_sys_i
    initial begin
        clk3_o = 1'b0;
        #37;
        forever begin
            #((slow_i ? 300 : 250));
            clk3_o = ~clk3_o;
        end
    end

endmodule : fsg_clk3_src

`default_nettype wire

/* File: bench/fsg_top_test.sv */
/*
 * Self-checking bench for fsg_top with a shortened 2 kHz period.
 * Assumes fsg_clk3_src supplies output clock three.
 */
`timescale 1ns/1ps
`default_nettype none

module fsg_top_test;

    localparam int P2K = 80;

    logic       clk_sys_i = 1'b0;
    logic       arst_n_i  = 1'b0;
    logic       en8       = 1'b0;
    logic       pul8      = 1'b0;
    logic       inv8      = 1'b0;
    logic       en2       = 1'b0;
    logic       pul2      = 1'b0;
    logic       inv2      = 1'b0;
    logic       slow      = 1'b0;
    logic       ce        = 1'b1;
    logic       clk3;
    logic       fpin;
    logic       mpin;
    logic [7:0] lo8, fa8, lo2, fa2, mff, mfr;
    int         fails     = 0;
    int         n_tests   = 0;
    int         cycles    = 0;

    // {en8,pul8,inv8,en2,pul2,inv2}
    logic [5:0] cfg_tab  [6] = '{6'b100100, 6'b101100, 6'b110110, 6'b111111, 6'b011011, 6'b100011};
    logic       slow_tab [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    // frame lows, frame falls, mframe lows, mframe falls, joint falls, mframe fall with frame rise
    logic [7:0] exp_tab  [6][6] = '{
        '{8'h50, 8'h08, 8'h50, 8'h02, 8'h02, 8'h00},
        '{8'h50, 8'h08, 8'h50, 8'h02, 8'h00, 8'h02},
        '{8'h28, 8'h08, 8'h0a, 8'h02, 8'h02, 8'h00},
        '{8'h70, 8'h08, 8'h94, 8'h02, 8'h02, 8'h00},
        '{8'ha0, 8'h00, 8'ha0, 8'h00, 8'h00, 8'h00},
        '{8'h50, 8'h08, 8'ha0, 8'h00, 8'h00, 8'h00}};

    always #50 clk_sys_i = ~clk_sys_i;

    fsg_clk3_src u_src (
        .slow_i (slow),
        .clk3_o (clk3)
    );

    fsg_top #(
        .PERIOD_2K_CYC (P2K)
    ) u_dut (
        .clk_sys_i                (clk_sys_i),
        .arst_n_i                 (arst_n_i),
        .ce_i                     (ce),
        .frame_out_enable_i       (en8),
        .pulse_mode_8k_i          (pul8),
        .invert_8k_i              (inv8),
        .multiframe_out_enable_i  (en2),
        .pulse_mode_2k_i          (pul2),
        .invert_2k_i              (inv2),
        .output_clock_three_i     (clk3),
        .frame_sync_8k_out_o      (fpin),
        .multiframe_sync_2k_out_o (mpin)
    );

    // ==========================================
    // reporting
    task automatic print_verdict;
        if (fails == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_tests++;
        if (seen !== want) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    // ==========================================
    // one full multiframe pair of samples
    task automatic measure;
        logic pf;
        logic pm;
        pf = fpin;
        pm = mpin;
        {lo8, fa8, lo2, fa2, mff, mfr} = '0;
        repeat (2 * P2K) begin
            @(negedge clk_sys_i);
            if (fpin === 1'b0) lo8++;
            if (mpin === 1'b0) lo2++;
            if (pf === 1'b1 && fpin === 1'b0) fa8++;
            if (pm === 1'b1 && mpin === 1'b0) fa2++;
            if (pm === 1'b1 && mpin === 1'b0 && pf === 1'b1 && fpin === 1'b0) mff++;
            if (pm === 1'b1 && mpin === 1'b0 && pf === 1'b0 && fpin === 1'b1) mfr++;
            pf = fpin;
            pm = mpin;
        end
    endtask : measure

    // ==========================================
    // timeout
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end

    // ==========================================
    // main sequence
    initial begin
        repeat (4) @(negedge clk_sys_i);
        check({6'h00, fpin, mpin}, 8'h00);
        arst_n_i = 1'b1;
        // config changes land at frame phase 15, clear of edges and pulses
        repeat (15) @(negedge clk_sys_i);
        for (int i = 0; i < 6; i++) begin
            {en8, pul8, inv8, en2, pul2, inv2} = cfg_tab[i];
            slow = slow_tab[i];
            repeat (200) @(negedge clk_sys_i);
            measure();
            check(lo8, exp_tab[i][0]);
            check(fa8, exp_tab[i][1]);
            check(lo2, exp_tab[i][2]);
            check(fa2, exp_tab[i][3]);
            check(mff, exp_tab[i][4]);
            check(mfr, exp_tab[i][5]);
        end
        // enable low freezes frame clock high at phase 15, multiframe off
        ce = 1'b0;
        repeat (30) @(negedge clk_sys_i);
        check({6'h00, fpin, mpin}, 8'h02);
        ce = 1'b1;
        print_verdict();
    end

endmodule : fsg_top_test

`default_nettype wire
